// ### hw/ddcs_top.sv
// How it works
// - Select pin low means pin control, high means serial control.
// - With select high, act as a standard serial target.
// - Shared pins become chip select, data in, data out, clock.
// - First byte out is always the status register at address one.
// - Second byte out answers the received address, whatever the direction.
// - Sample data in on rising edge, change data out on falling edge.
// - Status top bit set after power-on recovery, cleared by reading status.
// - Pin mode style: high-side, low-side on sink select, push-pull on push-pull select.
// - Serial mode ignores style pins and uses serial configuration.
// - Disabled is high-Z; transmit picks high or low per style.
// - Drive-mode field 11 forces that output high-Z.
// - Static level 1 drives high unless low-side or drive-mode 11, ignoring enable and transmit.
// - Tracking uses main channel enable and transmit for both outputs.
// - Tracking makes auxiliary use main channel configuration.
// - Tracking turns both outputs off on a fault on either.
// - Tracking flags only the faulting output.
// - Tracking enable is bit 5 of device configuration.
// - Floating limit pin flags overcurrent at once but keeps driver on.
`timescale 1ns/1ps
`default_nettype none
module ddcs_top
   import ddcs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              spi_mode_pin,
   input  wire logic              select_or_pushpull_pin,
   input  wire logic              datain_or_sink_select_pin,
   input  wire logic              spi_clk_pin,
   input  wire logic              main_channel_enable,
   input  wire logic              main_channel_transmit,
   input  wire logic              aux_channel_enable,
   input  wire logic              aux_channel_transmit,
   input  wire ddcs_chan_cfg_type main_cfg,
   input  wire ddcs_chan_cfg_type aux_cfg,
   input  wire logic [1:0]        fault_raw,
   input  wire logic [1:0]        limit_setting_pin_floating,
   input  wire logic [6:0]        status_low,
   input  wire logic [7:0]        reg_read_data,
   output logic                   dataout_or_fault_pin,
   output logic                   dataout_oe,
   output ddcs_out_type           comm_line_output,
   output ddcs_out_type           aux_line_output,
   output logic [1:0]             fault_flag,
   output logic                   output_tracking_bit,
   output logic [6:0]             reg_addr,
   output logic                   reg_write,
   output logic [7:0]             reg_wdata
);
   // Three-stage pin synchronisers
   logic [2:0] mode_s_reg, cs_s_reg, sdi_s_reg, sck_s_reg;
   logic [2:0] en1_s_reg, tx1_s_reg, en2_s_reg, tx2_s_reg;
   logic mode_reg, cs_n_reg, sdi_reg, sck_reg, en1_reg, tx1_reg, en2_reg, tx2_reg;
   always_ff @(posedge clk) begin
      mode_s_reg <= {mode_s_reg[1:0], spi_mode_pin};
      cs_s_reg   <= {cs_s_reg[1:0], select_or_pushpull_pin};
      sdi_s_reg  <= {sdi_s_reg[1:0], datain_or_sink_select_pin};
      sck_s_reg  <= {sck_s_reg[1:0], spi_clk_pin};
      en1_s_reg  <= {en1_s_reg[1:0], main_channel_enable};
      tx1_s_reg  <= {tx1_s_reg[1:0], main_channel_transmit};
      en2_s_reg  <= {en2_s_reg[1:0], aux_channel_enable};
      tx2_s_reg  <= {tx2_s_reg[1:0], aux_channel_transmit};
   end
   // A level is accepted once stages two and three agree
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         sdi_reg  <= 1'b0;
         sck_reg  <= 1'b0;
         en1_reg  <= 1'b0;
         tx1_reg  <= 1'b0;
         en2_reg  <= 1'b0;
         tx2_reg  <= 1'b0;
      end else begin
         if (mode_s_reg[2] == mode_s_reg[1]) mode_reg <= mode_s_reg[2];
         if (cs_s_reg[2] == cs_s_reg[1]) cs_n_reg <= cs_s_reg[2];
         if (sdi_s_reg[2] == sdi_s_reg[1]) sdi_reg <= sdi_s_reg[2];
         if (sck_s_reg[2] == sck_s_reg[1]) sck_reg <= sck_s_reg[2];
         if (en1_s_reg[2] == en1_s_reg[1]) en1_reg <= en1_s_reg[2];
         if (tx1_s_reg[2] == tx1_s_reg[1]) tx1_reg <= tx1_s_reg[2];
         if (en2_s_reg[2] == en2_s_reg[1]) en2_reg <= en2_s_reg[2];
         if (tx2_s_reg[2] == tx2_s_reg[1]) tx2_reg <= tx2_s_reg[2];
      end
   end

   wire spi_mode = mode_reg;
   wire frame    = spi_mode && !cs_n_reg;
   logic sck_prev_reg;
   wire sck_up   = frame && sck_reg && !sck_prev_reg;
   wire sck_down = frame && !sck_reg && sck_prev_reg;

   // Serial frame engine
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_in_reg, shift_out_reg;
   logic [6:0] addr_reg;
   logic       rd_reg, por_reg, track_reg;
   logic       sdo_reg, sdo_oe_reg, wr_reg;
   logic [7:0] wdata_reg;
   wire [7:0]  rx_byte   = {shift_in_reg[6:0], sdi_reg};
   wire [7:0]  status    = {por_reg, status_low};
   wire        byte0_end = sck_up && bit_cnt_reg == 4'h7;
   wire        byte1_end = sck_up && bit_cnt_reg == DDCS_BITS_LAST;
   wire        status_rd = byte0_end && rx_byte[0] && rx_byte[7:1] == DDCS_STATUS_ADDR;
   wire [7:0]  answer    = (rx_byte[7:1] == DDCS_STATUS_ADDR) ? status
                         : (rx_byte[7:1] == DDCS_DEVCFG_ADDR)
                         ? {2'h0, track_reg, 5'h00} : reg_read_data;

   always_ff @(posedge clk) begin
      if (srst) begin
         sck_prev_reg  <= 1'b0;
         bit_cnt_reg   <= 4'h0;
         shift_in_reg  <= 8'h00;
         shift_out_reg <= 8'h00;
         addr_reg      <= 7'h00;
         rd_reg        <= 1'b0;
         por_reg       <= 1'b1;
         track_reg     <= DDCS_DEVCFG_RESET[DDCS_TRACK_BIT];
         sdo_reg       <= 1'b0;
         sdo_oe_reg    <= 1'b0;
         wr_reg        <= 1'b0;
         wdata_reg     <= 8'h00;
      end else begin
         sck_prev_reg <= sck_reg;
         wr_reg       <= 1'b0;
         sdo_oe_reg   <= frame;
         if (!frame) begin
            bit_cnt_reg   <= 4'h0;
            shift_out_reg <= status;
            sdo_reg       <= status[7];
         end else if (sck_up) begin
            shift_in_reg <= rx_byte;
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            if (byte0_end) begin
               addr_reg      <= rx_byte[7:1];
               rd_reg        <= rx_byte[0];
               shift_out_reg <= answer;
            end
            if (byte1_end && !rd_reg) begin
               wr_reg    <= 1'b1;
               wdata_reg <= rx_byte;
               if (addr_reg == DDCS_DEVCFG_ADDR) track_reg <= rx_byte[DDCS_TRACK_BIT];
            end
         end else if (sck_down) begin
            // Bit 7 leads; next bit appears on the falling edge
            sdo_reg       <= (bit_cnt_reg == 4'h8) ? shift_out_reg[7] : shift_out_reg[6];
            if (bit_cnt_reg != 4'h8) shift_out_reg <= {shift_out_reg[6:0], 1'b0};
         end
         // Read of status clears the recovery bit
         if (status_rd) por_reg <= 1'b0;
      end
   end

   // Drive style and channel selection
   wire tracking = spi_mode && track_reg;
   wire [1:0] pin_style = select_or_pp_style(cs_n_reg, sdi_reg);
   function automatic logic [1:0] select_or_pp_style(input logic pp, input logic sink);
      select_or_pp_style = pp ? DDCS_MODE_PP : (sink ? DDCS_MODE_LOW : DDCS_MODE_HIGH);
   endfunction
   function automatic ddcs_out_type decode(input logic spi, input logic [1:0] style,
                                           input logic level, input logic en, input logic tx);
      decode = '{drive_en: 1'b0, level: 1'b0};
      if (spi && style == DDCS_MODE_DISABLED) decode = '{drive_en: 1'b0, level: 1'b0};
      else if (spi && level) begin
         if (style != DDCS_MODE_LOW) decode = '{drive_en: 1'b1, level: 1'b1};
      end else if (en) begin
         if (!tx && style != DDCS_MODE_LOW) decode = '{drive_en: 1'b1, level: 1'b1};
         else if (tx && style != DDCS_MODE_HIGH) decode = '{drive_en: 1'b1, level: 1'b0};
      end
   endfunction

   wire ddcs_chan_cfg_type cfg1 = main_cfg;
   wire ddcs_chan_cfg_type cfg2 = tracking ? main_cfg : aux_cfg;
   wire [1:0] style1 = spi_mode ? cfg1.drive_mode : pin_style;
   wire [1:0] style2 = spi_mode ? cfg2.drive_mode : pin_style;
   wire en2 = tracking ? en1_reg : en2_reg;
   wire tx2 = tracking ? tx1_reg : tx2_reg;
   // Floating limit pin flags but never switches the driver off
   wire [1:0] trip = fault_raw & ~limit_setting_pin_floating;
   wire [1:0] kill = tracking ? {2{|trip}} : trip;
   wire ddcs_out_type o1 = decode(spi_mode, style1, cfg1.static_level, en1_reg, tx1_reg);
   wire ddcs_out_type o2 = decode(spi_mode, style2, cfg2.static_level, en2, tx2);

   always_ff @(posedge clk) begin
      if (srst) begin
         comm_line_output <= '{drive_en: 1'b0, level: 1'b0};
         aux_line_output  <= '{drive_en: 1'b0, level: 1'b0};
         fault_flag       <= 2'h0;
      end else begin
         comm_line_output <= kill[0] ? '{drive_en: 1'b0, level: 1'b0} : o1;
         aux_line_output  <= kill[1] ? '{drive_en: 1'b0, level: 1'b0} : o2;
         fault_flag       <= fault_raw;
      end
   end

   always_comb begin
      dataout_or_fault_pin = sdo_reg;
      dataout_oe           = sdo_oe_reg;
      output_tracking_bit  = track_reg;
      reg_addr             = addr_reg;
      reg_write            = wr_reg;
      reg_wdata            = wdata_reg;
   end

   a_status_first: assert property (@(posedge clk) disable iff (srst)
      $fell(cs_n_reg) && spi_mode |=> shift_out_reg == $past(status))
      else $error("status byte not loaded at frame start");
   a_por_clear: assert property (@(posedge clk) disable iff (srst)
      status_rd |=> !por_reg) else $error("recovery bit not cleared");
   a_track_both_off: assert property (@(posedge clk) disable iff (srst)
      tracking && |trip |=> !comm_line_output.drive_en && !aux_line_output.drive_en)
      else $error("tracking fault left an output on");
   a_disabled_hiz: assert property (@(posedge clk) disable iff (srst)
      spi_mode && cfg1.drive_mode == DDCS_MODE_DISABLED |=> !comm_line_output.drive_en)
      else $error("disabled channel driving");
   a_float_keeps: assert property (@(posedge clk) disable iff (srst)
      !tracking && limit_setting_pin_floating[0] |=> comm_line_output == $past(o1))
      else $error("floating limit disabled driver");
   a_write_track: assert property (@(posedge clk) disable iff (srst)
      byte1_end && !rd_reg && addr_reg == DDCS_DEVCFG_ADDR |=> track_reg == $past(rx_byte[5]))
      else $error("tracking bit not written");
   a_sdo_oe: assert property (@(posedge clk) disable iff (srst)
      !frame |=> !dataout_oe) else $error("data out driven outside frame");
   a_fault_flag: assert property (@(posedge clk) disable iff (srst)
      fault_raw == 2'h1 |=> fault_flag == 2'h1) else $error("wrong output flagged");
   c_track: cover property (@(posedge clk) tracking && en1_reg);
   c_status_rd: cover property (@(posedge clk) status_rd);
   c_write: cover property (@(posedge clk) wr_reg);
endmodule
`default_nettype wire

// ### hw/ddcs_pkg.sv
package ddcs_pkg;
   // Drive styles
   typedef enum logic [1:0] {
      DDCS_STYLE_HIGH = 2'h0,
      DDCS_STYLE_LOW  = 2'h1,
      DDCS_STYLE_PP   = 2'h2
   } ddcs_style_type;

   // Per-channel configuration from the serial side
   typedef struct packed {
      logic [1:0] drive_mode;
      logic       static_level;
   } ddcs_chan_cfg_type;

   // Output stage control: drive enable and level
   typedef struct packed {
      logic drive_en;
      logic level;
   } ddcs_out_type;

   localparam logic [6:0] DDCS_STATUS_ADDR   = 7'h01;
   localparam logic [6:0] DDCS_DEVCFG_ADDR   = 7'h02;
   localparam int         DDCS_TRACK_BIT     = 5;
   localparam int         DDCS_POR_BIT       = 7;
   localparam logic [1:0] DDCS_MODE_DISABLED = 2'h3;
   localparam logic [1:0] DDCS_MODE_HIGH     = 2'h0;
   localparam logic [1:0] DDCS_MODE_LOW      = 2'h1;
   localparam logic [1:0] DDCS_MODE_PP       = 2'h2;
   localparam logic [7:0] DDCS_DEVCFG_RESET  = 8'h00;
   localparam logic [3:0] DDCS_BITS_LAST     = 4'hF;
endpackage

// ### testbench/ddcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddcs_host_model (
   input  wire logic clk,
   input  wire logic sdo,
   output logic      cs_n,
   output logic      sdi,
   output logic      sck
);
   initial begin
      cs_n = 1'b1;
      sdi  = 1'b0;
      sck  = 1'b0;
   end
   // Half period of 8 clk leaves room for the device's pin synchronisers
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi <= tx[i];
         repeat (8) @(posedge clk);
         sck <= 1'b1;
         rx[i] = sdo;
         repeat (8) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (8) @(posedge clk);
      cs_n <= 1'b1;
      sdi  <= ~sdi;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_ddcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ddcs_top;
   import ddcs_pkg::*;
   logic              clk = 1'b0, srst = 1'b1, spi_mode = 1'b1, pp = 1'b0, sink = 1'b0;
   logic              men = 1'b0, mtx = 1'b0, aen = 1'b0, atx = 1'b0;
   ddcs_chan_cfg_type mcfg = 3'h0, acfg = 3'h0;
   logic [1:0]        flt = 2'h0, flo = 2'h0, ff;
   logic [6:0]        stat = 7'h2B, ra;
   logic [7:0]        rdat = 8'hA5, wd;
   logic              cs_n, sdi, sck, sdo, sdo_oe, trk, wr;
   ddcs_out_type      cq, aq;
   logic [15:0]       rx;
   int                num_errors = 0, checks_done = 0, wr_cnt = 0, oe_gaps = 0;
   always #10 clk = ~clk;
   always @(posedge clk) if (wr === 1'b1) wr_cnt++;
   // Serial clock only runs inside a frame, so data out must be enabled then
   always @(posedge clk) if (sck === 1'b1 && sdo_oe !== 1'b1) oe_gaps++;
   ddcs_host_model host (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sdi(sdi), .sck(sck));
   ddcs_top dut (.clk(clk), .srst(srst), .spi_mode_pin(spi_mode),
      .select_or_pushpull_pin(spi_mode ? cs_n : pp),
      .datain_or_sink_select_pin(spi_mode ? sdi : sink), .spi_clk_pin(sck),
      .main_channel_enable(men), .main_channel_transmit(mtx),
      .aux_channel_enable(aen), .aux_channel_transmit(atx), .main_cfg(mcfg),
      .aux_cfg(acfg), .fault_raw(flt), .limit_setting_pin_floating(flo),
      .status_low(stat), .reg_read_data(rdat), .dataout_or_fault_pin(sdo),
      .dataout_oe(sdo_oe), .comm_line_output(cq), .aux_line_output(aq),
      .fault_flag(ff), .output_tracking_bit(trk), .reg_addr(ra),
      .reg_write(wr), .reg_wdata(wd));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Level is a don't-care while the stage is off
   task automatic chk_out(string n, logic [1:0] e, ddcs_out_type g);
      chk(n, {6'h00, e[1], e[1] & e[0]}, {6'h00, g.drive_en, e[1] & g.level});
   endtask
   function automatic logic [1:0] expo(logic [1:0] st, logic lv, logic en, logic tx);
      if (st == DDCS_MODE_DISABLED) return 2'b00;
      if (lv) return {st != DDCS_MODE_LOW, 1'b1};
      if (!en) return 2'b00;
      if (!tx) return {st != DDCS_MODE_LOW, 1'b1};
      return {st != DDCS_MODE_HIGH, 1'b0};
   endfunction
   task automatic settle();
      repeat (12) @(posedge clk);
   endtask
   task automatic t_frames();
      host.xfer({DDCS_STATUS_ADDR, 1'b1, 8'h00}, rx);
      chk("status first", {1'b1, stat}, rx[15:8]);
      host.xfer({7'h03, 1'b1, 8'h00}, rx);
      chk("status again", {1'b0, stat}, rx[15:8]);
      chk("answer byte", rdat, rx[7:0]);
      chk("address", 8'h03, {1'b0, ra});
      chk("read pulses", 8'h00, 8'(wr_cnt));
      chk("oe in frame", 8'h00, 8'(oe_gaps));
      chk("oe idle", 8'h00, {7'h00, sdo_oe});
      $display("test frames done");
   endtask
   task automatic t_write(logic [7:0] v);
      int c0;
      c0 = wr_cnt;
      host.xfer({DDCS_DEVCFG_ADDR, 1'b0, v}, rx);
      settle();
      chk("write data", v, wd);
      chk("write pulse", 8'h01, 8'(wr_cnt - c0));
      chk("tracking", {7'h00, v[DDCS_TRACK_BIT]}, {7'h00, trk});
      host.xfer({DDCS_DEVCFG_ADDR, 1'b1, 8'h00}, rx);
      chk("config read", {2'h0, v[DDCS_TRACK_BIT], 5'h00}, rx[7:0]);
   endtask
   task automatic t_decode(logic tr);
      logic [1:0] st;
      logic       l, e, t;
      t_write(tr ? 8'h20 : 8'h00);
      for (int k = 0; k < 32; k++) begin
         {st, l, e, t} = 5'(k);
         mcfg <= {st, l};
         acfg <= {2'(st + 2'h1), ~l};
         men  <= e;
         mtx  <= t;
         aen  <= ~e;
         atx  <= ~t;
         settle();
         chk_out("main out", expo(st, l, e, t), cq);
         if (tr)
            chk_out("aux track", expo(st, l, e, t), aq);
         else
            chk_out("aux out", expo(2'(st + 2'h1), ~l, ~e, ~t), aq);
      end
      $display("test decode done");
   endtask
   task automatic t_fault();
      t_write(8'h20);
      mcfg <= {DDCS_MODE_PP, 1'b0};
      men  <= 1'b1;
      mtx  <= 1'b0;
      flt  <= 2'b10;
      settle();
      chk_out("main on fault", 2'b00, cq);
      chk_out("aux on fault", 2'b00, aq);
      chk("fault flags", 8'h02, {6'h00, ff});
      flt <= 2'b00;
      t_write(8'h00);
      flo <= 2'b01;
      flt <= 2'b01;
      settle();
      chk("floating flag", 8'h01, {6'h00, ff});
      chk_out("floating out", 2'b11, cq);
      flt <= 2'b00;
      flo <= 2'b00;
      $display("test fault done");
   endtask
   task automatic t_pin();
      logic [1:0] st;
      t_write(8'h20);
      spi_mode <= 1'b0;
      mcfg     <= {DDCS_MODE_DISABLED, 1'b0};
      for (int k = 0; k < 16; k++) begin
         {pp, sink, men, mtx} <= 4'(k);
         aen <= ~k[1];
         atx <= ~k[0];
         st  = k[3] ? DDCS_MODE_PP : (k[2] ? DDCS_MODE_LOW : DDCS_MODE_HIGH);
         settle();
         chk_out("pin main", expo(st, 1'b0, k[1], k[0]), cq);
         chk_out("pin aux", expo(st, 1'b0, ~k[1], ~k[0]), aq);
      end
      $display("test pin done");
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (8) @(posedge clk);
      t_frames();
      t_decode(1'b0);
      t_decode(1'b1);
      t_fault();
      t_pin();
      finish_test();
   end
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      $display("[FAIL] watchdog expected done seen hang");
      finish_test();
   end
endmodule
`default_nettype wire
